// *** logic/adc_id_status_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the id/status pair
`ifndef ADC_ID_STATUS_CFG_SVH
`define ADC_ID_STATUS_CFG_SVH

// Register addresses on the register-command port
`define ADDR_DEVICE_IDENTITY        8'h00
`define ADDR_DEVICE_CONDITION_FLAGS 8'h01

// Reset value of the condition flags register
`define CONDITION_FLAGS_RESET       8'h80

// Bit positions within the condition flags register
`define BIT_POWER_ON_SEEN           7
`define BIT_NOT_READY               6
`define BIT_POS_OUT_HIGH_RAIL       5
`define BIT_POS_OUT_LOW_RAIL        4
`define BIT_NEG_OUT_HIGH_RAIL       3
`define BIT_NEG_OUT_LOW_RAIL        2
`define BIT_REF_BELOW_THIRD         1
`define BIT_REF_MISSING             0

// Identity register layout
`define MODEL_CODE_MSB              2
`define ID_RESERVED_VALUE           5'h00

// Start-up time before the device reports ready, and clock period
`define STARTUP_TIME_NS             1000
`define CORE_CLK_PERIOD_NS          10
`define STARTUP_CYCLES \
  ((`STARTUP_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`endif

// *** logic/adc_id_status_pkg.sv ***
// Types shared by the id/status register pair
package adc_id_status_pkg;

  // Comparator levels from the analog monitors, one bit each
  typedef struct packed {
    logic pos_out_high_rail;
    logic pos_out_low_rail;
    logic neg_out_high_rail;
    logic neg_out_low_rail;
    logic ref_below_third;
    logic ref_missing;
  } monitor_s;

  // Start-up sequencer states
  typedef enum logic [0:0] {
    ST_STARTING = 1'b0,
    ST_READY    = 1'b1
  } startup_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// *** logic/adc_id_status_registers.sv ***
// Identification and condition flags registers of the converter
`timescale 1ns/1ps
`include "adc_id_status_cfg.svh"

module adc_id_status_registers #(
  parameter logic [2:0]  MODEL_CODE     = 3'h2, // Arbitrary neutral value
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  // Register command port from the command decoder
  input  wire logic                         reg_rd_i,
  input  wire logic                         reg_wr_i,
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic [7:0]                   reg_wdata_i,
  // Monitor enables held in other configuration registers
  input  wire logic                         rail_monitor_enable_i,
  input  wire logic [1:0]                   ref_monitor_enable_i,
  // Analog comparator levels
  input  wire adc_id_status_pkg::monitor_s  monitors_i,
  // Read answer and device-ready output
  output logic      [7:0]                   reg_rdata_o,
  output logic                              reg_rvalid_o,
  output logic                              device_ready_o
);

  // Start-up counter width, at least one bit
  localparam int CNT_W = (STARTUP_CYCLES > 1) ? $clog2(STARTUP_CYCLES + 1) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_CYCLES - 1);

  // State
  adc_id_status_pkg::startup_e  state_reg;
  adc_id_status_pkg::startup_e  state_next;
  logic [CNT_W-1:0]             count_reg;
  logic [CNT_W-1:0]             count_next;
  logic                         power_on_seen_reg;
  logic                         power_on_seen_next;
  logic [5:0]                   fault_reg;
  logic [5:0]                   fault_next;
  adc_id_status_pkg::reg_byte_t rdata_next;

  // Decoded strobes and selects
  wire logic       sel_identity;
  wire logic       sel_flags;
  wire logic       wr_flags;
  wire logic       rail_en;
  wire logic       ref_l0_en;
  wire logic       ref_l1_en;
  wire logic [5:0] fault_now;
  wire logic [5:0] fault_upd;
  wire logic [7:0] identity_byte;
  wire logic [7:0] flags_byte;

  // Pack six comparator levels into flag order, bit 5 down to bit 0
  function automatic logic [5:0] pack_faults(
    input adc_id_status_pkg::monitor_s m
  );
    pack_faults = {m.pos_out_high_rail, m.pos_out_low_rail,
                   m.neg_out_high_rail, m.neg_out_low_rail,
                   m.ref_below_third,   m.ref_missing};
  endfunction

  // Address decode
  // Register command decode
  assign sel_identity = (reg_addr_i == `ADDR_DEVICE_IDENTITY);
  assign sel_flags    = (reg_addr_i == `ADDR_DEVICE_CONDITION_FLAGS);
  assign wr_flags     = reg_wr_i && sel_flags;

  // Monitor enables; bit 1 of the ref field also enables the third level
  assign rail_en   = rail_monitor_enable_i;
  assign ref_l0_en = |ref_monitor_enable_i;
  assign ref_l1_en = ref_monitor_enable_i[1];
  assign fault_now = pack_faults(monitors_i);

  // Per-flag update enables
  // Rail flags gated
  assign fault_upd = {{4{rail_en}}, ref_l1_en, ref_l0_en};

  // Live flags follow comparators while enabled, else hold last value
  // Trade-off: a disabled monitor shows its last level, maybe stale
  // Rail and reference flags track levels
  assign fault_next = (fault_now & fault_upd) | (fault_reg & ~fault_upd);

  // Power-on flag takes only a host write, never a hardware set after reset
  // Cleared by host write
  assign power_on_seen_next = wr_flags ? reg_wdata_i[`BIT_POWER_ON_SEEN]
                                       : power_on_seen_reg;

  // Identity byte, reserved bits fixed
  // Reserved upper bits
  assign identity_byte = {`ID_RESERVED_VALUE, MODEL_CODE};

  // Condition flags byte
  // Not-ready bit
  assign flags_byte = {power_on_seen_reg, state_reg == 
                       adc_id_status_pkg::ST_STARTING, fault_reg};

  // Read mux; unmapped address answers zero
  assign rdata_next = sel_identity ? identity_byte :
                      sel_flags    ? flags_byte    : 8'h00;

  // Start-up sequencer: count cycles, then ready forever until reset
  // Counter parks once ready, so it can never wrap into a second start
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      adc_id_status_pkg::ST_STARTING: begin
        if (count_reg == CNT_LAST) begin
          state_next = adc_id_status_pkg::ST_READY;
        end else begin
          count_next = count_reg + CNT_W'(1);
        end
      end
      adc_id_status_pkg::ST_READY: begin
        count_next = count_reg;
      end
    endcase
  end

  // State registers
  // Reset value 80h
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg         <= adc_id_status_pkg::ST_STARTING;
      count_reg         <= '0;
      power_on_seen_reg <= 1'b1;
      fault_reg         <= 6'h00;
    end else begin
      state_reg         <= state_next;
      count_reg         <= count_next;
      power_on_seen_reg <= power_on_seen_next;
      fault_reg         <= fault_next;
    end
  end

  // Read answer one cycle after the request; data held until next read
  // Data is captured only on a read, so a late look still sees it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o    <= 8'h00;
      reg_rvalid_o   <= 1'b0;
      device_ready_o <= 1'b0;
    end else begin
      reg_rvalid_o   <= reg_rd_i;
      device_ready_o <= (state_next == adc_id_status_pkg::ST_READY);
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_next;
      end
    end
  end

  // Checks and coverage
  // All checks sleep through reset and watch port inputs as well as design-driven state
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Power-on flag is one right after every reset release
  chk_por_after_reset: assert property (
    $fell(rst_i) |-> power_on_seen_reg)
    else $error("power-on flag not set after reset");

  // Power-on flag changes only with a write to the flags register
  chk_por_write_only: assert property (
    !wr_flags |=> $stable(power_on_seen_reg))
    else $error("power-on flag moved without a write");

  // Written zero clears the flag, read back as zero
  chk_por_clear_read: assert property (
    wr_flags && !reg_wdata_i[7] ##1 !wr_flags
    ##1 reg_rd_i && sel_flags && !reg_wr_i
    |=> !reg_rdata_o[7])
    else $error("cleared power-on flag read back as one");

  // Identity read returns reserved zeros and the model code
  chk_id_read: assert property (
    reg_rd_i && sel_identity |=> reg_rvalid_o &&
    reg_rdata_o == {5'h00, MODEL_CODE})
    else $error("identity read wrong");

  // Not-ready bit is one for the whole start-up and zero afterwards
  chk_ready_bit: assert property (
    reg_rd_i && sel_flags |=> reg_rdata_o[6] == !$past(device_ready_o))
    else $error("ready bit disagrees with start-up state");

  // Ready rises no earlier than the start-up count
  chk_ready_time: assert property (
    $rose(device_ready_o) |-> $past(count_reg) == CNT_LAST)
    else $error("ready asserted at wrong time");

  // Rail flags follow the comparators one cycle later while enabled
  chk_rail_track: assert property (
    rail_monitor_enable_i |=> fault_reg[5:2] == $past(fault_now[5:2]))
    else $error("rail flags do not track comparators");

  // Rail flags freeze while monitor disabled
  chk_rail_hold: assert property (
    !rail_monitor_enable_i |=> $stable(fault_reg[5:2]))
    else $error("rail flags moved while disabled");

  // Reference flags gated by their enable field
  chk_ref_gate: assert property (
    ref_monitor_enable_i == 2'h0 |=> $stable(fault_reg[1:0]))
    else $error("reference flags moved while disabled");

  // Missing-reference flag follows its comparator when enabled
  chk_ref_track: assert property (
    ref_l0_en |=> fault_reg[0] == $past(monitors_i.ref_missing))
    else $error("missing-reference flag wrong");

  // Unmapped read answers zero
  chk_unmapped: assert property (
    reg_rd_i && !sel_identity && !sel_flags |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // Stored bits of the flags register match the reset value
  chk_reset_value: assert property (
    $fell(rst_i) |->
    {power_on_seen_reg, 1'b0, fault_reg} == `CONDITION_FLAGS_RESET)
    else $error("flags register reset value wrong");

  // Device is not ready right after reset release
  chk_not_ready_reset: assert property (
    $fell(rst_i) |-> !device_ready_o &&
    state_reg == adc_id_status_pkg::ST_STARTING)
    else $error("ready too early after reset");

  // Once ready, the device stays ready until the next reset
  chk_ready_stays: assert property (
    device_ready_o |=> device_ready_o)
    else $error("ready dropped without reset");

  // A write to the flags register stores bit 7 in the power-on flag
  chk_por_takes_write: assert property (
    reg_wr_i && reg_addr_i == `ADDR_DEVICE_CONDITION_FLAGS |=>
    power_on_seen_reg == $past(reg_wdata_i[`BIT_POWER_ON_SEEN]))
    else $error("power-on flag ignored a write");

  // Positive output high-rail comparator lands in bit 5
  chk_high_rail_map: assert property (
    rail_monitor_enable_i |=> fault_reg[`BIT_POS_OUT_HIGH_RAIL] ==
    $past(monitors_i.pos_out_high_rail))
    else $error("positive high-rail flag wrong");

  // Negative output low-rail comparator lands in bit 2
  chk_low_rail_map: assert property (
    rail_monitor_enable_i |=> fault_reg[`BIT_NEG_OUT_LOW_RAIL] ==
    $past(monitors_i.neg_out_low_rail))
    else $error("negative low-rail flag wrong");

  // One-third reference flag follows its comparator when enabled
  chk_third_track: assert property (
    ref_monitor_enable_i[1] |=> fault_reg[`BIT_REF_BELOW_THIRD] ==
    $past(monitors_i.ref_below_third))
    else $error("one-third reference flag wrong");

  // One-third reference flag freezes while its enable bit is low
  chk_third_hold: assert property (
    !ref_monitor_enable_i[1] |=> $stable(fault_reg[`BIT_REF_BELOW_THIRD]))
    else $error("one-third reference flag moved while disabled");

  // Every read is answered by valid one cycle later
  chk_read_valid: assert property (
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");

  // Valid is raised only in the cycle after a read, never without one
  chk_valid_pulse: assert property (
    !reg_rd_i |=> !reg_rvalid_o)
    else $error("valid without a read");

  // Read data stands until the next read
  chk_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  // A flags read returns the stored fault bits
  chk_flags_read: assert property (
    reg_rd_i && sel_flags |=> reg_rdata_o[5:0] == $past(fault_reg))
    else $error("flags read lost fault bits");

  // Main scenarios
  cov_por_clear:  cover property (wr_flags && !reg_wdata_i[7]);
  cov_ready:      cover property ($rose(device_ready_o));
  cov_rail_fault: cover property (rail_en ##1 fault_reg[5]);
  cov_ref_fault:  cover property (ref_l1_en ##1 fault_reg[1]);
  cov_early_read: cover property (reg_rd_i && sel_flags && !device_ready_o);

endmodule

// *** tb/host_model.sv ***
// Host model issuing register read and write commands
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic       clk_i,
  // Register command port towards the device
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  // Read answer from the device
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  // Idle port at time zero
  initial begin
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    // Released lines carry junk so stale values are never trusted
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask

  // register read command, answer one cycle after the take
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge clk_i);
    reg_rd_o   = 1'b1;
    reg_addr_o = a;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    ok         = (reg_rvalid_i === 1'b1);
    d          = reg_rdata_i;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the id and condition flags registers
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] MODEL = 3'h3; // Arbitrary model code

  logic       clk;
  logic       rst;
  logic       rd;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       rail_en;
  logic [1:0] ref_en;
  logic [5:0] mon;
  logic [7:0] rdata;
  logic       rvalid;
  logic       ready;
  logic [7:0] got;
  logic       ok;
  int         err_count;
  int         num_checks;

  // Short start-up count keeps the run brief
  adc_id_status_registers #(
    .MODEL_CODE     (MODEL),
    .STARTUP_CYCLES (2)
  ) dut (
    .core_clk_i            (clk),
    .rst_i                 (rst),
    .reg_rd_i              (rd),
    .reg_wr_i              (wr),
    .reg_addr_i            (addr),
    .reg_wdata_i           (wdata),
    .rail_monitor_enable_i (rail_en),
    .ref_monitor_enable_i  (ref_en),
    .monitors_i            (adc_id_status_pkg::monitor_s'(mon)),
    .reg_rdata_o           (rdata),
    .reg_rvalid_o          (rvalid),
    .device_ready_o        (ready)
  );

  host_model host (
    .clk_i        (clk),
    .reg_rd_o     (rd),
    .reg_wr_o     (wr),
    .reg_addr_o   (addr),
    .reg_wdata_o  (wdata),
    .reg_rdata_i  (rdata),
    .reg_rvalid_i (rvalid)
  );

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts one comparison and reports a mismatch
  task automatic flag(input bit cond, input string msg);
    num_checks++;
    if (!cond) begin
      $display("ERROR at %0t: %s", $time, msg);
      err_count++;
    end
  endtask

  // Masked compare so reserved bits never decide the outcome
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input logic [7:0] m);
    host.rd(a, got, ok);
    flag(ok === 1'b1 && (got & m) === (e & m), "read mismatch");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog far beyond the fewer than a hundred cycles the tests need
  initial begin
    #50000;
    err_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst     = 1'b1;
    rail_en = 1'b0;
    ref_en  = 2'b00;
    mon     = 6'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    flag(ready === 1'b0, "ready too early");
    repeat (4) @(negedge clk);
    flag(ready === 1'b1, "never ready");
    rdchk(8'h00, {5'h00, MODEL}, 8'h07);
    host.wr(8'h00, 8'hFF);
    rdchk(8'h00, {5'h00, MODEL}, 8'h07);
    rdchk(8'h01, 8'h80, 8'hFF);
    @(negedge clk);
    flag(rvalid === 1'b0 && rdata === got, "stale answer");
    host.wr(8'h01, 8'h7F);
    rdchk(8'h01, 8'h00, 8'hFF);
    rdchk(8'h05, 8'h00, 8'hFF);
    rail_en = 1'b1;
    ref_en  = 2'b11;
    // Each monitor alone lands in its own bit
    mon = 6'h20;
    rdchk(8'h01, 8'h20, 8'hFF);
    mon = 6'h10;
    rdchk(8'h01, 8'h10, 8'hFF);
    mon = 6'h08;
    rdchk(8'h01, 8'h08, 8'hFF);
    mon = 6'h04;
    rdchk(8'h01, 8'h04, 8'hFF);
    mon = 6'h02;
    rdchk(8'h01, 8'h02, 8'hFF);
    mon = 6'h01;
    rdchk(8'h01, 8'h01, 8'hFF);
    mon = 6'h00;
    rdchk(8'h01, 8'h00, 8'hFF);
    rail_en = 1'b0;
    ref_en  = 2'b00;
    mon     = 6'h3F;
    rdchk(8'h01, 8'h00, 8'hFF);
    rail_en = 1'b1;
    rdchk(8'h01, 8'h3C, 8'hFF);
    ref_en = 2'b01;
    rdchk(8'h01, 8'h3D, 8'hFF);
    ref_en = 2'b10;
    rdchk(8'h01, 8'h3F, 8'hFF);
    // Disabled monitors keep their last level, not clear to zero
    rail_en = 1'b0;
    ref_en  = 2'b00;
    mon     = 6'h00;
    rdchk(8'h01, 8'h3F, 8'hFF);
    rail_en = 1'b1;
    ref_en  = 2'b11;
    host.wr(8'h01, 8'h80);
    rdchk(8'h01, 8'h80, 8'hFF);
    host.wr(8'h01, 8'h00);
    // Second reset in mid-run brings the power-on flag back
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    // Read during start-up sees the not-ready bit still set
    rdchk(8'h01, 8'hC0, 8'hFF);
    repeat (4) @(negedge clk);
    rdchk(8'h01, 8'h80, 8'hFF);
    complete_run();
  end
endmodule
